// ---- verilog/cop1_pkg.sv ----
/*
 Package for the charge option one register block: offset, field
 positions, reset values, threshold shares and timing constants.
 Assumes a 10 MHz system clock and a word-wide host register port.
*/
package cop1_pkg;
   // Register address
   localparam logic [7:0] COP1_ADDR = 8'h3b;
   // Field positions
   localparam int DEPL_HI = 15;
   localparam int DEPL_LO = 14;
   localparam int RATIO_HI = 13;
   localparam int RATIO_LO = 12;
   localparam int DISCHARGE_CURRENT_MONITOR_EN_BIT = 11;
   localparam int SYSTEM_POWER_MONITOR_EN_BIT = 10;
   localparam int GAIN_BIT = 9;
   localparam int REF_BIT = 7;
   localparam int POL_BIT = 6;
   localparam int DEG_HI = 5;
   localparam int DEG_LO = 4;
   localparam int LATCH_BIT = 3;
   localparam int SHIP_BIT = 1;
   // Writable bits; bits 8, 2 and 0 stay zero
   localparam logic [15:0] COP1_WMASK = 16'hfefa;
   // Value after power-on reset
   localparam logic [15:0] COP1_RESET = 16'hc210;
   // Depletion threshold shares in hundredths of a percent
   localparam logic [13:0] DEPL_SHARE_0 = 14'h171f; // 59.19 percent
   localparam logic [13:0] DEPL_SHARE_1 = 14'h1879; // 62.65 percent
   localparam logic [13:0] DEPL_SHARE_2 = 14'h19ff; // 66.55 percent
   localparam logic [13:0] DEPL_SHARE_3 = 14'h1bb9; // 70.97 percent
   localparam logic [13:0] DEPL_FULL = 14'h2710; // 100 percent
   // Deglitch codes
   localparam logic [1:0] DEG_OFF = 2'h0;
   localparam logic [1:0] DEG_1US = 2'h1;
   localparam logic [1:0] DEG_2MS = 2'h2;
   // Clock and times in their own units
   localparam int CLK_HZ = 10_000_000;
   localparam int DEG_SHORT_NS = 1000;
   localparam int DEG_MID_MS = 2;
   localparam int DEG_LONG_S = 5;
   localparam int SHIP_MS = 140;
   // Cycle counts derived from the clock rate
   localparam int DEG_SHORT_CYC = DEG_SHORT_NS * (CLK_HZ / 1_000_000) / 1000;
   localparam int DEG_MID_CYC = DEG_MID_MS * (CLK_HZ / 1000);
   localparam int DEG_LONG_CYC = DEG_LONG_S * CLK_HZ;
   localparam int SHIP_CYC = SHIP_MS * (CLK_HZ / 1000);
   // Width of all timers
   localparam int CNT_W = 27;
endpackage : cop1_pkg

// ---- verilog/cop1_deglitch.sv ----
/*
 Falling-edge deglitch filter for the comparator output.
 Assumes the raw level is synchronous to the clock and the limit
 is steady while a low run is being timed.
*/
`timescale 1ns/1ns
module cop1_deglitch
   import cop1_pkg::*;
#(
   parameter int W = CNT_W // Timer width
) (
   input wire logic i_clk, // System clock
   input wire logic i_rst, // Async reset, active high
   input wire logic i_raw, // Undelayed output level
   input wire logic [W-1:0] i_limit, // Low run length in cycles
   output logic o_level // Filtered output level
);
   logic [W-1:0] cnt_q; // Length of the current low run

   // Rise passes at once; a low run must last i_limit cycles
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_q <= '0;
         o_level <= 1'b1;
      end else if (i_raw) begin
         // Short glitches high restart the low timing
         cnt_q <= '0;
         o_level <= 1'b1;
      end else if (o_level) begin
         if (cnt_q + 1'b1 >= i_limit) begin
            o_level <= 1'b0;
         end
         cnt_q <= cnt_q + 1'b1;
      end
   end
endmodule : cop1_deglitch

// ---- verilog/cop1_top.sv ----
/*
 Charge option one register and the control logic it steers:
 depletion checks for battery_calibration_mode and boost, monitor enables, comparator
 filtering, power path latch-off and the shipping discharge timer.
 Assumes an outside bus engine turns host word transfers into
 one-cycle read and write strobes, and that analog blocks deliver
 digital levels and millivolt codes synchronous to I_MCLK.
*/
`timescale 1ns/1ns
module cop1_top
   import cop1_pkg::*;
#(
   parameter int DEG_MID = DEG_MID_CYC, // 2 ms deglitch cycles
   parameter int DEG_LONG = DEG_LONG_CYC, // 5 s deglitch cycles
   parameter int SHIP_LEN = SHIP_CYC // Shipping discharge cycles
) (
   input wire logic I_MCLK, // 10 MHz clock
   input wire logic I_RST, // Power-on reset, active high
   input wire logic [7:0] I_REG_ADDR, // Register address
   input wire logic [15:0] I_REG_WDATA, // Write word
   input wire logic I_REG_WR, // Write strobe
   input wire logic I_REG_RD, // Read strobe
   output logic [15:0] O_REG_RDATA, // Read word
   input wire logic [15:0] I_BAT_MV, // Battery voltage
   input wire logic [15:0] I_VREG_MV, // Voltage regulation limit
   input wire logic I_BATTERY_CALIBRATION_MODE_REQ, // Battery_calibration_mode mode requested
   input wire logic I_BOOST_REQ, // Boost mode requested
   input wire logic I_ADAPTER_INPUT_SWITCH_REQ, // Source select wants adapter switch
   input wire logic I_REVERSE_BLOCK_SWITCH_REQ, // Source select wants reverse block
   input wire logic I_BATTERY_PATH_SWITCH_REQ, // Source select wants battery switch
   input wire logic I_CMP_ABOVE, // Comparator input above reference
   output logic O_BATTERY_CALIBRATION_MODE_ACTIVE, // Battery_calibration_mode mode running
   output logic O_BOOST_ACTIVE, // Boost mode running
   output logic O_ADAPTER_INPUT_SWITCH_ON, // Adapter input switch on
   output logic O_REVERSE_BLOCK_SWITCH_ON, // Reverse block switch on
   output logic O_BATTERY_PATH_SWITCH_ON, // Battery path switch on
   output logic O_DISCHARGE_CURRENT_MONITOR_EN, // Discharge monitor output enabled
   output logic O_SYSTEM_POWER_MONITOR_EN, // Power monitor output enabled
   output logic [1:0] O_SENSE_RATIO, // Resistor ratio code
   output logic [3:0] O_SYSTEM_POWER_MONITOR_SCALE, // Gain in 0.25 uA/W steps
   output logic O_COMPARATOR_REFERENCE_SELECT_LOW, // 1.2 V reference selected
   output logic O_CMP_EN, // Comparator powered
   output logic O_CMP_OUT, // Filtered comparator output
   output logic O_LATCHED_OFF, // Power path latched off
   output logic O_SHIP_SINK // Battery sense node sink on
);
   logic [15:0] reg_q; // Stored register word
   logic wr_hit; // Write to this register
   logic [29:0] bat_scaled; // Battery times full share
   logic [29:0] lim_scaled; // Limit times selected share
   logic [13:0] share; // Selected threshold share
   logic depleted; // Battery under threshold
   logic battery_calibration_mode_blk_q; // Battery_calibration_mode stopped by depletion
   logic boost_blk_q; // Boost stopped by depletion
   logic battery_calibration_mode_now; // Battery_calibration_mode allowed this cycle
   logic boost_now; // Boost allowed this cycle
   logic cmp_raw; // Comparator output before filter
   logic cmp_filt; // Comparator output after filter
   logic cmp_trig; // Comparator in its tripped state
   logic [CNT_W-1:0] deg_limit; // Selected deglitch length
   logic latch_q; // Power path latch
   logic [CNT_W-1:0] ship_cnt_q; // Shipping discharge timer
   logic ship_end; // Last timer cycle
   logic [3:0] low_run_q; // Cycles the raw comparator level sat low

   assign wr_hit = I_REG_WR && (I_REG_ADDR == COP1_ADDR);

   // word write port
   // Whole word written at once; reserved bits masked out
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         reg_q <= COP1_RESET;
      end else begin
         if (wr_hit) begin
            reg_q <= I_REG_WDATA & COP1_WMASK;
         end
         if (ship_end && !(wr_hit && I_REG_WDATA[SHIP_BIT])) begin
            reg_q[SHIP_BIT] <= 1'b0;
         end
      end
   end

   // address decode on read
   // Other addresses return zero so the bus engine can share one mux
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         O_REG_RDATA <= '0;
      end else if (I_REG_RD) begin
         O_REG_RDATA <= (I_REG_ADDR == COP1_ADDR) ? reg_q : '0;
      end
   end

   always_comb begin
      unique case (reg_q[DEPL_HI:DEPL_LO])
         2'h0: share = DEPL_SHARE_0;
         2'h1: share = DEPL_SHARE_1;
         2'h2: share = DEPL_SHARE_2;
         2'h3: share = DEPL_SHARE_3;
      endcase
   end

   // Compare in scaled form to avoid a divider
   assign bat_scaled = I_BAT_MV * DEPL_FULL;
   assign lim_scaled = I_VREG_MV * share;
   assign depleted = bat_scaled < lim_scaled;
   assign battery_calibration_mode_now = I_BATTERY_CALIBRATION_MODE_REQ && !battery_calibration_mode_blk_q && !depleted;
   assign boost_now = I_BOOST_REQ && !boost_blk_q && !depleted;

   // battery_calibration_mode exit on depletion
   // Stays out until the request drops, so no chatter near threshold
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         battery_calibration_mode_blk_q <= 1'b0;
      end else if (!I_BATTERY_CALIBRATION_MODE_REQ) begin
         battery_calibration_mode_blk_q <= 1'b0;
      end else if (depleted) begin
         battery_calibration_mode_blk_q <= 1'b1;
      end
   end

   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         boost_blk_q <= 1'b0;
      end else if (!I_BOOST_REQ) begin
         boost_blk_q <= 1'b0;
      end else if (depleted) begin
         boost_blk_q <= 1'b1;
      end
   end

   // Mode and switch outputs, registered
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         O_BATTERY_CALIBRATION_MODE_ACTIVE <= 1'b0;
         O_BOOST_ACTIVE <= 1'b0;
         O_ADAPTER_INPUT_SWITCH_ON <= 1'b0;
         O_REVERSE_BLOCK_SWITCH_ON <= 1'b0;
         O_BATTERY_PATH_SWITCH_ON <= 1'b0;
      end else begin
         O_BATTERY_CALIBRATION_MODE_ACTIVE <= battery_calibration_mode_now;
         O_BOOST_ACTIVE <= boost_now;
         O_ADAPTER_INPUT_SWITCH_ON <= I_ADAPTER_INPUT_SWITCH_REQ && !battery_calibration_mode_now && !latch_q;
         O_REVERSE_BLOCK_SWITCH_ON <= I_REVERSE_BLOCK_SWITCH_REQ && !battery_calibration_mode_now && !latch_q;
         O_BATTERY_PATH_SWITCH_ON <= I_BATTERY_PATH_SWITCH_REQ || battery_calibration_mode_now;
      end
   end

   // Monitor and comparator setting outputs
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         O_DISCHARGE_CURRENT_MONITOR_EN <= 1'b0;
         O_SYSTEM_POWER_MONITOR_EN <= 1'b0;
         O_SENSE_RATIO <= 2'h0;
         O_SYSTEM_POWER_MONITOR_SCALE <= 4'h4;
         O_COMPARATOR_REFERENCE_SELECT_LOW <= 1'b0;
         O_CMP_EN <= 1'b1;
      end else begin
         O_DISCHARGE_CURRENT_MONITOR_EN <= reg_q[DISCHARGE_CURRENT_MONITOR_EN_BIT];
         O_SYSTEM_POWER_MONITOR_EN <= reg_q[SYSTEM_POWER_MONITOR_EN_BIT];
         O_SENSE_RATIO <= reg_q[RATIO_HI:RATIO_LO];
         O_SYSTEM_POWER_MONITOR_SCALE <= (reg_q[GAIN_BIT] ? 4'h4 : 4'h1)
                         << (reg_q[RATIO_HI:RATIO_LO] != 2'h0);
         O_COMPARATOR_REFERENCE_SELECT_LOW <= reg_q[REF_BIT];
         O_CMP_EN <= reg_q[DEG_HI:DEG_LO] != DEG_OFF;
      end
   end

   always_comb begin
      unique case (reg_q[DEG_HI:DEG_LO])
         DEG_OFF: deg_limit = CNT_W'(DEG_SHORT_CYC);
         DEG_1US: deg_limit = CNT_W'(DEG_SHORT_CYC);
         DEG_2MS: deg_limit = CNT_W'(DEG_MID);
         default: deg_limit = CNT_W'(DEG_LONG);
      endcase
   end

   // polarity of raw output
   // A disabled comparator rests high, its untripped level at polarity zero
   assign cmp_raw = (reg_q[DEG_HI:DEG_LO] == DEG_OFF) ? 1'b1 :
                    (reg_q[POL_BIT] ? I_CMP_ABOVE : !I_CMP_ABOVE);

   cop1_deglitch #(
      .W (CNT_W)
   ) u_deglitch (
      .i_clk (I_MCLK),
      .i_rst (I_RST),
      .i_raw (cmp_raw),
      .i_limit (deg_limit),
      .o_level (cmp_filt)
   );

   assign O_CMP_OUT = cmp_filt;
   // Tripped means the input sits above the reference after filtering
   assign cmp_trig = (reg_q[DEG_HI:DEG_LO] != DEG_OFF) &&
                     (reg_q[POL_BIT] ? cmp_filt : !cmp_filt);

   // latch held until cleared
   // A zero write wins over a trip in the same cycle
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         latch_q <= 1'b0;
      end else if (wr_hit && !I_REG_WDATA[LATCH_BIT]) begin
         latch_q <= 1'b0;
      end else if (reg_q[LATCH_BIT] && cmp_trig) begin
         latch_q <= 1'b1;
      end
   end
   assign O_LATCHED_OFF = latch_q;

   // shipping discharge timer
   // A second one while running does not restart the timer
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         ship_cnt_q <= '0;
         O_SHIP_SINK <= 1'b0;
      end else if (!reg_q[SHIP_BIT] || ship_end) begin
         ship_cnt_q <= '0;
         O_SHIP_SINK <= 1'b0;
      end else begin
         ship_cnt_q <= ship_cnt_q + 1'b1;
         O_SHIP_SINK <= 1'b1;
      end
   end
   assign ship_end = ship_cnt_q == CNT_W'(SHIP_LEN);

   // Checks
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (I_RST);

   // Low run length of the raw level, saturating; the filter timer is private,
   // so the checks keep their own count instead of peeking inside it
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         low_run_q <= 4'h0;
      end else if (cmp_raw) begin
         low_run_q <= 4'h0;
      end else if (low_run_q != 4'hf) begin
         low_run_q <= low_run_q + 4'h1;
      end
   end

   sequence s_ship_start;
      !reg_q[SHIP_BIT] ##1 reg_q[SHIP_BIT];
   endsequence

   a_resv_bits_zero: assert property (
      I_REG_RD |=> (O_REG_RDATA & ~COP1_WMASK) == 16'h0000)
      else $error("reserved bits read nonzero");
   a_read_decode: assert property (
      I_REG_RD && I_REG_ADDR != COP1_ADDR |=> O_REG_RDATA == 16'h0000)
      else $error("unmapped read returned data");
   a_battery_calibration_mode_exit: assert property (
      I_BATTERY_CALIBRATION_MODE_REQ && depleted |=> !O_BATTERY_CALIBRATION_MODE_ACTIVE ##1 !O_BATTERY_CALIBRATION_MODE_ACTIVE)
      else $error("battery_calibration_mode kept while depleted");
   a_boost_exit: assert property (
      I_BOOST_REQ && depleted |=> !O_BOOST_ACTIVE)
      else $error("boost kept while depleted");
   a_battery_calibration_mode_switch: assert property (
      O_BATTERY_CALIBRATION_MODE_ACTIVE |-> !O_ADAPTER_INPUT_SWITCH_ON && !O_REVERSE_BLOCK_SWITCH_ON && O_BATTERY_PATH_SWITCH_ON)
      else $error("battery_calibration_mode switch pattern wrong");
   a_cmp_rise_fast: assert property (
      $rose(cmp_raw) |=> cmp_filt)
      else $error("rising comparator edge delayed");
   a_cmp_fall_short: assert property (
      reg_q[DEG_HI:DEG_LO] == DEG_1US && cmp_filt && !cmp_raw &&
      low_run_q >= 4'(DEG_SHORT_CYC - 1) |=> !cmp_filt)
      else $error("short deglitch did not fall");
   a_cmp_hold_short: assert property (
      reg_q[DEG_HI:DEG_LO] == DEG_1US && cmp_filt && !cmp_raw &&
      low_run_q < 4'(DEG_SHORT_CYC - 1) |=> cmp_filt)
      else $error("short deglitch fell early");
   a_latch_hold: assert property (
      latch_q && !(wr_hit && !I_REG_WDATA[LATCH_BIT]) |=> latch_q && !O_ADAPTER_INPUT_SWITCH_ON)
      else $error("latch released without clear");
   a_latch_set: assert property (
      reg_q[LATCH_BIT] && cmp_trig && !wr_hit |=> latch_q ##1 !O_REVERSE_BLOCK_SWITCH_ON)
      else $error("trip did not latch off");
   a_ship_run: assert property (
      s_ship_start |=> O_SHIP_SINK [*8])
      else $error("shipping sink not running");
   a_ship_clear: assert property (
      $fell(reg_q[SHIP_BIT]) && !$past(wr_hit) |-> $past(ship_cnt_q) == CNT_W'(SHIP_LEN))
      else $error("shipping bit cleared early");
   a_gain_scale: assert property (
      ##1 reg_q[GAIN_BIT] && reg_q[RATIO_HI:RATIO_LO] == 2'h0 |=> O_SYSTEM_POWER_MONITOR_SCALE == 4'h4)
      else $error("power monitor scale wrong");
   a_cmp_disabled: assert property (
      reg_q[DEG_HI:DEG_LO] == DEG_OFF |=> O_CMP_OUT)
      else $error("disabled comparator output low");
   a_latch_clear: assert property (
      wr_hit && !I_REG_WDATA[LATCH_BIT] |=> !latch_q)
      else $error("zero write kept latch");
   a_ship_stop: assert property (
      ship_end |=> !O_SHIP_SINK)
      else $error("shipping sink ran past its end");
endmodule : cop1_top

// ---- tb/cop1_host.sv ----
/*
 Host model for the charge option one register port: word writes
 and reads as one-cycle strobes.
 Assumes the block samples strobes on the rising clock edge.
*/
`timescale 1ns/1ns
module cop1_host (
   input wire logic i_clk, // System clock
   input wire logic [15:0] i_rdata, // Read word
   output logic [7:0] o_addr, // Register address
   output logic [15:0] o_wdata, // Write word
   output logic o_wr, // Write strobe
   output logic o_rd // Read strobe
);
   // Idle at time zero
   initial begin
      o_addr = 8'h00;
      o_wdata = 16'h0000;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end
   // host word write
   // Strobe rises on a falling edge and drops one cycle later
   task automatic wr_word(input logic [7:0] a, input logic [15:0] d);
      @(negedge i_clk);
      o_addr = a;
      o_wdata = d;
      o_wr = 1'b1;
      @(negedge i_clk);
      o_wr = 1'b0;
      // Released data shows the inverse, not a stale word
      o_wdata = ~d;
   endtask : wr_word
   // Read word is taken once the strobe edge has landed
   task automatic rd_word(input logic [7:0] a, output logic [15:0] d);
      @(negedge i_clk);
      o_addr = a;
      o_rd = 1'b1;
      @(negedge i_clk);
      o_rd = 1'b0;
      d = i_rdata;
   endtask : rd_word
endmodule : cop1_host

// ---- tb/cop1_top_tb_top.sv ----
/*
 Self-checking bench for the charge option one block.
 Assumes timers shortened by parameters and a host model driving the port.
*/
`timescale 1ns/1ns
module cop1_top_tb_top;
   import cop1_pkg::*;
   typedef struct packed {
      logic [15:0] wd; // Written word
      logic [15:0] rd; // Expected readback
      logic [1:0] ratio; // Expected ratio code
      logic [3:0] scale; // Expected gain steps
      logic [3:0] flags; // Monitor enables, reference, comparator on
   } cop1_row_t;
   localparam int SHIP_N = 50; // Shortened discharge length
   logic clk = 1'b0, rst = 1'b1, above = 1'b0; // Clock, reset, comparator input
   logic battery_calibration_mode = 1'b0, boost = 1'b0, acr = 1'b1, rbr = 1'b1, batr = 1'b0; // Requests
   logic [15:0] bat = 16'h2710, vreg = 16'h2710, v; // Voltages, read word
   logic [7:0] addr; // Host address
   logic [15:0] wdata, rdata; // Host data
   logic wr, rd; // Host strobes
   logic l_act, b_act, ac_on, rb_on, bat_on, id_en, pm_en, ref_lo, c_en, c_out, lat, sink;
   logic [1:0] ratio; // Ratio code out
   logic [3:0] scale; // Gain out
   int error_cnt = 0, samples_checked = 0, cycles = 0, n;
   // Ordinary settings: reserved bits, ratio codes, gain doubling
   cop1_row_t rows [5] = '{
      '{16'h0105, 16'h0000, 2'h0, 4'h1, 4'h0},
      '{16'h1e80, 16'h1e80, 2'h1, 4'h8, 4'he},
      '{16'h2060, 16'h2060, 2'h2, 4'h2, 4'h1},
      '{16'h3230, 16'h3230, 2'h3, 4'h8, 4'h1},
      '{16'hc210, 16'hc210, 2'h0, 4'h4, 4'h1}};
   logic [15:0] shares [4] = '{16'h171f, 16'h1879, 16'h19ff, 16'h1bb9};
   int lens [3] = '{10, 40, 80};
   always #50 clk = ~clk;
   cop1_host host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
      .o_wr(wr), .o_rd(rd));
   cop1_top #(.DEG_MID(40), .DEG_LONG(80), .SHIP_LEN(SHIP_N)) uut (
      .I_MCLK(clk), .I_RST(rst), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
      .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata), .I_BAT_MV(bat),
      .I_VREG_MV(vreg), .I_BATTERY_CALIBRATION_MODE_REQ(battery_calibration_mode), .I_BOOST_REQ(boost), .I_ADAPTER_INPUT_SWITCH_REQ(acr),
      .I_REVERSE_BLOCK_SWITCH_REQ(rbr), .I_BATTERY_PATH_SWITCH_REQ(batr), .I_CMP_ABOVE(above),
      .O_BATTERY_CALIBRATION_MODE_ACTIVE(l_act), .O_BOOST_ACTIVE(b_act), .O_ADAPTER_INPUT_SWITCH_ON(ac_on),
      .O_REVERSE_BLOCK_SWITCH_ON(rb_on), .O_BATTERY_PATH_SWITCH_ON(bat_on), .O_DISCHARGE_CURRENT_MONITOR_EN(id_en), .O_SYSTEM_POWER_MONITOR_EN(pm_en),
      .O_SENSE_RATIO(ratio), .O_SYSTEM_POWER_MONITOR_SCALE(scale), .O_COMPARATOR_REFERENCE_SELECT_LOW(ref_lo),
      .O_CMP_EN(c_en), .O_CMP_OUT(c_out), .O_LATCHED_OFF(lat), .O_SHIP_SINK(sink));
   // Verdict and end of run, reached from the sequence or the watchdog
   task automatic test_done();
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done
   // Four-state compare so an unknown never matches
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Reset for four cycles, then defaults must read back
   task automatic rst_chk();
      rst = 1'b1;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      host.rd_word(COP1_ADDR, v);
      chk(v, 16'hc210);
      chk({scale, c_en, c_out, lat, sink}, {4'h4, 4'hc});
   endtask : rst_chk
   // Watchdog: a hang counts as a mismatch
   always @(posedge clk) begin
      cycles++;
      if (cycles >= 20000) begin
         error_cnt++;
         test_done();
      end
   end
   initial begin
      rst_chk();
      // Table of field settings, each read back
      foreach (rows[i]) begin
         host.wr_word(COP1_ADDR, rows[i].wd);
         host.rd_word(COP1_ADDR, v);
         chk(v, rows[i].rd);
         chk({ratio, scale}, {rows[i].ratio, rows[i].scale});
         chk({id_en, pm_en, ref_lo, c_en}, rows[i].flags);
      end
      // Other address: write ignored, read gives zero
      host.wr_word(8'h3a, 16'h0000);
      host.rd_word(8'h3a, v);
      chk(v, 16'h0000);
      host.rd_word(COP1_ADDR, v);
      chk(v, 16'hc210);
      // Each threshold code: enter at the limit, leave one step below
      for (int k = 0; k < 4; k++) begin
         host.wr_word(COP1_ADDR, {k[1:0], 14'h0010});
         bat = shares[k];
         battery_calibration_mode = 1'b1;
         boost = 1'b1;
         repeat (2) @(negedge clk);
         chk({l_act, b_act, ac_on, rb_on, bat_on}, 5'h19);
         bat = shares[k] - 16'h0001;
         repeat (2) @(negedge clk);
         chk({l_act, b_act, ac_on, rb_on, bat_on}, 5'h06);
         battery_calibration_mode = 1'b0;
         boost = 1'b0;
      end
      bat = 16'h2710;
      // Deglitch lengths; the last code also arms the latch-off
      for (int j = 1; j < 4; j++) begin
         host.wr_word(COP1_ADDR, {10'h000, j[1:0], (j == 3), 3'h0});
         above = 1'b1;
         repeat (lens[j-1] - 1) @(negedge clk);
         chk(c_out, 1'b1);
         @(negedge clk);
         chk(c_out, 1'b0);
         @(negedge clk);
         chk(lat, (j == 3));
         @(negedge clk);
         chk({ac_on, rb_on}, (j == 3) ? 2'h0 : 2'h3);
         above = 1'b0;
         @(negedge clk);
         chk({c_out, lat}, {1'b1, (j == 3)});
      end
      // Zero write to the enable releases the latch
      host.wr_word(COP1_ADDR, 16'h0030);
      @(negedge clk);
      chk({lat, ac_on, rb_on}, 3'h3);
      // Polarity one: low after the short deglitch, high at once, no latch
      host.wr_word(COP1_ADDR, 16'h0050);
      repeat (9) @(negedge clk);
      chk(c_out, 1'b1);
      @(negedge clk);
      chk(c_out, 1'b0);
      above = 1'b1;
      @(negedge clk);
      chk({c_out, lat}, 2'h2);
      // Disabled comparator rests high with the input held low
      host.wr_word(COP1_ADDR, 16'h0000);
      above = 1'b0;
      repeat (12) @(negedge clk);
      chk({c_out, c_en}, 2'h2);
      // Shipping discharge runs its length and clears its own bit
      host.wr_word(COP1_ADDR, 16'h0002);
      chk(sink, 1'b0);
      @(negedge clk);
      chk(sink, 1'b1);
      n = 0;
      while (sink === 1'b1 && n < 200) begin
         n++;
         @(negedge clk);
      end
      chk(n[15:0], SHIP_N[15:0]);
      host.rd_word(COP1_ADDR, v);
      chk(v, 16'h0000);
      // Reset in mid-run restores every default
      host.wr_word(COP1_ADDR, 16'h3ef8);
      rst_chk();
      test_done();
   end
endmodule : cop1_top_tb_top
